// ### rtl/cbl_cmp_unit.sv
// Subtract-and-compare flag generator
`timescale 1ns/1ps
module cbl_cmp_unit (
	input wire logic [7:0] i_a, // Minuend
	input wire logic [7:0] i_b, // Subtrahend
	input wire logic i_use_carry, // Also subtract carry-in
	input wire logic i_carry, // Current carry flag
	input wire logic i_zero, // Current zero flag
	output logic o_c, // Borrow out
	output logic o_z, // Zero result
	output logic o_n, // Negative result
	output logic o_v, // Signed overflow
	output logic o_s, // Sign test
	output logic o_h // Borrow from bit 3
);
	logic [7:0] res;
	logic cin;

	// Difference is used only for flags and then dropped
	always_comb begin
		cin = i_use_carry & i_carry;
		res = 8'(i_a - i_b - {7'h00, cin});
		o_h = (~i_a[3] & i_b[3]) | (i_b[3] & res[3]) | (res[3] & ~i_a[3]);
		o_c = (~i_a[7] & i_b[7]) | (i_b[7] & res[7]) | (res[7] & ~i_a[7]);
		o_v = (i_a[7] & ~i_b[7] & ~res[7]) | (~i_a[7] & i_b[7] & res[7]);
		o_n = res[7];
		o_s = o_n ^ o_v;
		// With carry the zero flag can only stay or fall, for multi-byte chains
		o_z = (res == 8'h00) & (~i_use_carry | i_zero);
	end
endmodule // cbl_cmp_unit

// ### rtl/cbl_core.sv
// Execution core for compares, skips, flag branches, moves and indirect loads
//
// What this block does
// - Equal registers skip next instruction, flags kept
// - Compares set six flags, one cycle
// - Register bit clear or set skips next
// - I/O bit clear or set skips next
// - Indexed flag branch jumps by offset plus one
// - Zero, carry, negative branches via flag index
// - Signed branches test the sign flag, which compares set to negative xor overflow
// - Half, transfer, overflow, interrupt flag branches
// - Pointer load reads byte, optional post-increment
// - Pre-decrement pointer then load, two cycles
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module cbl_core
	import cbl_pkg::*;
#(
	parameter int PC_W = 16, // Program counter width in bits
	parameter int ADDR_W = 8 // APB address width
) (
	input wire logic i_ref_clk, // Core clock
	input wire logic i_rst_n, // Asynchronous reset, active low
	input wire logic i_ce, // Clock enable, freezes all state when low
	output logic [PC_W-1:0] o_pc, // Program memory word address
	input wire logic [15:0] i_instr, // Instruction word at o_pc
	output logic [15:0] o_dmem_addr, // Data memory byte address
	output logic o_dmem_rd, // Data read strobe, data due on i_dmem_data
	input wire logic [7:0] i_dmem_data, // Data memory read data
	input wire logic [255:0] i_io_bits, // Low 32 I/O registers, bit per line
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB enable
	input wire logic i_pwrite, // APB write
	input wire logic [ADDR_W-1:0] i_paddr, // APB byte address
	input wire logic [31:0] i_pwdata, // APB write data
	output logic [31:0] o_prdata, // APB read data
	output logic o_pready, // APB ready
	output logic o_pslverr // APB error for unmapped address
);
	import cbl_pkg::*;

	logic [7:0] regs_q [32];
	logic [7:0] flags_q;
	logic [PC_W-1:0] pc_q;
	cbl_state_e st_q;
	logic [4:0] load_dst_q;
	logic run_q;
	logic [15:0] dmem_addr_q;
	logic dmem_rd_q;
	logic [31:0] prdata_q;

	logic exec;
	logic [4:0] rd5;
	logic [4:0] rr5;
	logic [4:0] rd_hi;
	logic [7:0] imm;
	logic [7:0] rd_val;
	logic [7:0] rr_val;
	logic is_skeq, is_cmpr, is_cmpc, is_cmpi, is_copy, is_pcopy, is_limm;
	logic is_skrc, is_skrs, is_skic, is_skis, is_bfs, is_bfc;
	logic is_ldx, is_ldy, is_load, is_long, is_cmp;
	logic reg_bit, io_bit, flag_bit;
	logic skip_go, br_go;
	logic [PC_W-1:0] br_target;
	logic y_sel;
	logic [15:0] ptr;
	logic [15:0] ptr_new;
	logic [15:0] load_addr;
	logic [7:0] cmp_a;
	logic [7:0] cmp_b;
	logic f_c, f_z, f_n, f_v, f_s, f_h;
	logic apb_wr, apb_setup, addr_ok;

	// Field extraction and operand reads
	assign exec = i_ce & run_q & (st_q == ST_EXEC);
	assign rd5 = i_instr[8:4];
	assign rr5 = {i_instr[9], i_instr[3:0]};
	assign rd_hi = {1'b1, i_instr[7:4]};
	assign imm = {i_instr[11:8], i_instr[3:0]};
	assign rd_val = regs_q[rd5];
	assign rr_val = regs_q[rr5];

	// Opcode decode
	assign is_skeq = (i_instr & OP_SKEQ_M) == OP_SKEQ_V;
	assign is_cmpr = (i_instr & OP_CMPR_M) == OP_CMPR_V;
	assign is_cmpc = (i_instr & OP_CMPC_M) == OP_CMPC_V;
	assign is_cmpi = (i_instr & OP_CMPI_M) == OP_CMPI_V;
	assign is_copy = (i_instr & OP_COPY_M) == OP_COPY_V;
	assign is_pcopy = (i_instr & OP_PCOPY_M) == OP_PCOPY_V;
	assign is_limm = (i_instr & OP_LIMM_M) == OP_LIMM_V;
	assign is_skrc = (i_instr & OP_SKRC_M) == OP_SKRC_V;
	assign is_skrs = (i_instr & OP_SKRS_M) == OP_SKRS_V;
	assign is_skic = (i_instr & OP_SKIC_M) == OP_SKIC_V;
	assign is_skis = (i_instr & OP_SKIS_M) == OP_SKIS_V;
	assign is_bfs = (i_instr & OP_BFS_M) == OP_BFS_V;
	assign is_bfc = (i_instr & OP_BFC_M) == OP_BFC_V;
	assign is_ldx = ((i_instr & OP_LDX_M) == OP_LDX_V) & (i_instr[1:0] != 2'h3);
	assign is_ldy = ((i_instr & OP_LDY_M) == OP_LDY_V) | ((i_instr & OP_LDY_M) == OP_LDYP_V)
		| ((i_instr & OP_LDY_M) == OP_LDYD_V);
	assign is_load = is_ldx | is_ldy;
	assign is_cmp = is_cmpr | is_cmpc | is_cmpi;
	assign is_long = ((i_instr & OP_LDS_M) == OP_LDS_V) | ((i_instr & OP_JMP_M) == OP_JMP_V);

	// Skip and branch conditions
	assign reg_bit = rd_val[i_instr[2:0]];
	assign io_bit = i_io_bits[{i_instr[7:3], i_instr[2:0]}];
	// Any status bit by index covers the named and signed branches
	assign flag_bit = flags_q[i_instr[2:0]];
	assign skip_go = (is_skeq & (rd_val == rr_val))
		| (is_skrc & ~reg_bit) | (is_skrs & reg_bit)
		| (is_skic & ~io_bit) | (is_skis & io_bit);
	assign br_go = (is_bfs & flag_bit) | (is_bfc & ~flag_bit);
	assign br_target = PC_W'(pc_q + PC_W'(signed'(i_instr[9:3])) + PC_W'(1));

	// Pointer selection and address arithmetic
	assign y_sel = is_ldy;
	assign ptr = y_sel ? {regs_q[Y_HI_IDX], regs_q[Y_LO_IDX]} : {regs_q[X_HI_IDX], regs_q[X_LO_IDX]};
	assign load_addr = (i_instr[1:0] == PTR_PRE) ? 16'(ptr - 16'h0001) : ptr;
	assign ptr_new = (i_instr[1:0] == PTR_POST) ? 16'(ptr + 16'h0001) : load_addr;

	// Compare operands: immediate form uses the upper register bank
	assign cmp_a = is_cmpi ? regs_q[rd_hi] : rd_val;
	assign cmp_b = is_cmpi ? imm : rr_val;

	cbl_cmp_unit u_cmp (
		.i_a(cmp_a),
		.i_b(cmp_b),
		.i_use_carry(is_cmpc),
		.i_carry(flags_q[FLAG_C]),
		.i_zero(flags_q[FLAG_Z]),
		.o_c(f_c),
		.o_z(f_z),
		.o_n(f_n),
		.o_v(f_v),
		.o_s(f_s),
		.o_h(f_h)
	);

	// Sequencer and program counter
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= ST_EXEC;
			pc_q <= '0;
		end else if (i_ce) begin
			case (st_q)
				ST_EXEC: begin
					if (run_q) begin
						if (br_go) begin
							pc_q <= br_target;
							st_q <= ST_STALL;
						end else if (skip_go) begin
							pc_q <= PC_W'(pc_q + PC_W'(1));
							st_q <= ST_SKIP;
						end else begin
							pc_q <= PC_W'(pc_q + PC_W'(1));
							st_q <= is_load ? ST_LOAD : ST_EXEC;
						end
					end
				end
				ST_SKIP: begin
					// Step over the skipped word, and its second word if long
					pc_q <= PC_W'(pc_q + PC_W'(1));
					st_q <= is_long ? ST_SKIP2 : ST_EXEC;
				end
				ST_SKIP2: begin
					pc_q <= PC_W'(pc_q + PC_W'(1));
					st_q <= ST_EXEC;
				end
				ST_LOAD: st_q <= ST_EXEC;
				ST_STALL: st_q <= ST_EXEC;
				default: st_q <= ST_EXEC;
			endcase
		end
	end

	// Register file: copies, immediates, pointer updates and load returns
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < 32; i++) begin
				regs_q[i] <= GPR_RST;
			end
			load_dst_q <= 5'h00;
		end else if (i_ce) begin
			if (st_q == ST_LOAD) begin
				regs_q[load_dst_q] <= i_dmem_data;
			end else if (exec) begin
				if (is_copy) begin
					regs_q[rd5] <= rr_val;
				end
				if (is_pcopy) begin
					regs_q[{i_instr[7:4], 1'b0}] <= regs_q[{i_instr[3:0], 1'b0}];
					regs_q[{i_instr[7:4], 1'b1}] <= regs_q[{i_instr[3:0], 1'b1}];
				end
				if (is_limm) begin
					regs_q[rd_hi] <= imm;
				end
				if (is_load) begin
					load_dst_q <= rd5;
					regs_q[y_sel ? Y_LO_IDX : X_LO_IDX] <= ptr_new[7:0];
					regs_q[y_sel ? Y_HI_IDX : X_HI_IDX] <= ptr_new[15:8];
				end
			end
		end
	end

	// Data memory read request, registered so strobe and data share the load cycle
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dmem_addr_q <= 16'h0000;
			dmem_rd_q <= 1'b0;
		end else if (i_ce) begin
			dmem_rd_q <= exec & is_load & ~br_go & ~skip_go;
			if (exec & is_load) begin
				dmem_addr_q <= load_addr;
			end
		end
	end

	// Status flags: compare results win over a software write
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flags_q <= FLAGS_RST;
		end else if (i_ce) begin
			if (exec & is_cmp) begin
				flags_q[FLAG_C] <= f_c;
				flags_q[FLAG_Z] <= f_z;
				flags_q[FLAG_N] <= f_n;
				flags_q[FLAG_V] <= f_v;
				flags_q[FLAG_S] <= f_s;
				flags_q[FLAG_H] <= f_h;
			end else if (apb_wr & (i_paddr == REG_FLAGS)) begin
				flags_q <= i_pwdata[7:0];
			end
		end
	end

	// APB decode, zero wait states
	assign apb_setup = i_psel & ~i_penable;
	assign apb_wr = i_psel & i_penable & i_pwrite;
	assign addr_ok = (i_paddr == REG_CTRL) | (i_paddr == REG_FLAGS) | (i_paddr == REG_PC)
		| (i_paddr == REG_PTR);
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel & i_penable & ~addr_ok;

	// Run control register
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run_q <= CTRL_RUN_RST;
		end else if (i_ce & apb_wr & (i_paddr == REG_CTRL)) begin
			run_q <= i_pwdata[CTRL_RUN_BIT];
		end
	end

	// Read data captured in the setup phase
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prdata_q <= 32'h0000_0000;
		end else if (i_ce & apb_setup) begin
			case (i_paddr)
				REG_CTRL: prdata_q <= {31'h0000_0000, run_q};
				REG_FLAGS: prdata_q <= {24'h00_0000, flags_q};
				REG_PC: prdata_q <= 32'(pc_q);
				REG_PTR: prdata_q <= {regs_q[Y_HI_IDX], regs_q[Y_LO_IDX], regs_q[X_HI_IDX],
					regs_q[X_LO_IDX]};
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign o_prdata = prdata_q;
	assign o_pc = pc_q;
	assign o_dmem_addr = dmem_addr_q;
	assign o_dmem_rd = dmem_rd_q;

	// Checks on execution timing and effects
	equal_skip_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
		exec && is_skeq && (rd_val == rr_val) |=> st_q == ST_SKIP && pc_q == PC_W'($past(pc_q) + 1)
		&& $stable(flags_q)) else $error("equal skip did not start");
	cmp_flags_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
		exec && is_cmpr |=> flags_q[FLAG_Z] == ($past(rd_val) == $past(rr_val)) && st_q == ST_EXEC
		&& regs_q[$past(rd5)] == $past(rd_val)) else $error("compare flag or timing wrong");
	cmp_carry_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
		exec && is_cmpi |=> flags_q[FLAG_C] == ($past(regs_q[rd_hi]) < $past(imm)))
		else $error("immediate compare carry wrong");
	reg_bit_skip_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
		exec && (is_skrc || is_skrs) && !br_go |=> (st_q == ST_SKIP)
		== ($past(is_skrs) == $past(reg_bit))) else $error("register bit skip wrong");
	io_bit_skip_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
		exec && (is_skic || is_skis) |=> (st_q == ST_SKIP) == ($past(is_skis) == $past(io_bit))
		&& $stable(flags_q)) else $error("io bit skip wrong");
	skip_length_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
		st_q == ST_SKIP && is_long |=> st_q == ST_SKIP2 ##1 st_q == ST_EXEC
		&& pc_q == PC_W'($past(pc_q, 2) + 2)) else $error("long skip wrong");
	branch_taken_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
		exec && br_go |=> pc_q == $past(br_target) && st_q == ST_STALL ##1 st_q == ST_EXEC)
		else $error("taken branch target or timing wrong");
	signed_branch_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
		exec && is_bfs && i_instr[2:0] == 3'(FLAG_S) && flags_q[FLAG_S]
		== (flags_q[FLAG_N] ^ flags_q[FLAG_V]) |-> br_go == (flags_q[FLAG_N] ^ flags_q[FLAG_V]))
		else $error("signed branch condition wrong");
	load_post_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
		exec && is_load && i_instr[1:0] == PTR_POST |=> o_dmem_addr == $past(ptr) && o_dmem_rd
		##1 regs_q[$past(load_dst_q)] == $past(i_dmem_data)) else $error("post-inc load wrong");
	load_pre_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
		exec && is_load && i_instr[1:0] == PTR_PRE |=> o_dmem_addr == 16'($past(ptr) - 1)
		&& st_q == ST_LOAD && $stable(flags_q)) else $error("pre-dec load wrong");
	copy_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_ce)
		exec && is_copy |=> regs_q[$past(rd5)] == $past(rr_val) && st_q == ST_EXEC
		&& $stable(flags_q)) else $error("register copy wrong");
endmodule // cbl_core

// ### rtl/cbl_pkg.sv
// Shared constants for the compare, branch and load execution block
package cbl_pkg;

	// Status flag bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	localparam logic [7:0] FLAGS_RST = 8'h00;

	// Pointer register indices in the register file
	localparam logic [4:0] X_LO_IDX = 5'h1A;
	localparam logic [4:0] X_HI_IDX = 5'h1B;
	localparam logic [4:0] Y_LO_IDX = 5'h1C;
	localparam logic [4:0] Y_HI_IDX = 5'h1D;
	localparam logic [7:0] GPR_RST = 8'h00;

	// Instruction encodings as mask and match value
	localparam logic [15:0] OP_SKEQ_M = 16'hFC00;
	localparam logic [15:0] OP_SKEQ_V = 16'h1000;
	localparam logic [15:0] OP_CMPR_M = 16'hFC00;
	localparam logic [15:0] OP_CMPR_V = 16'h1400;
	localparam logic [15:0] OP_CMPC_M = 16'hFC00;
	localparam logic [15:0] OP_CMPC_V = 16'h0400;
	localparam logic [15:0] OP_CMPI_M = 16'hF000;
	localparam logic [15:0] OP_CMPI_V = 16'h3000;
	localparam logic [15:0] OP_COPY_M = 16'hFC00;
	localparam logic [15:0] OP_COPY_V = 16'h2C00;
	localparam logic [15:0] OP_PCOPY_M = 16'hFF00;
	localparam logic [15:0] OP_PCOPY_V = 16'h0100;
	localparam logic [15:0] OP_LIMM_M = 16'hF000;
	localparam logic [15:0] OP_LIMM_V = 16'hE000;
	localparam logic [15:0] OP_SKRC_M = 16'hFE08;
	localparam logic [15:0] OP_SKRC_V = 16'hFC00;
	localparam logic [15:0] OP_SKRS_M = 16'hFE08;
	localparam logic [15:0] OP_SKRS_V = 16'hFE00;
	localparam logic [15:0] OP_SKIC_M = 16'hFF00;
	localparam logic [15:0] OP_SKIC_V = 16'h9900;
	localparam logic [15:0] OP_SKIS_M = 16'hFF00;
	localparam logic [15:0] OP_SKIS_V = 16'h9B00;
	localparam logic [15:0] OP_BFS_M = 16'hFC00;
	localparam logic [15:0] OP_BFS_V = 16'hF000;
	localparam logic [15:0] OP_BFC_M = 16'hFC00;
	localparam logic [15:0] OP_BFC_V = 16'hF400;
	localparam logic [15:0] OP_LDX_M = 16'hFE0C;
	localparam logic [15:0] OP_LDX_V = 16'h900C;
	localparam logic [15:0] OP_LDY_M = 16'hFE0F;
	localparam logic [15:0] OP_LDY_V = 16'h8008;
	localparam logic [15:0] OP_LDYP_V = 16'h9009;
	localparam logic [15:0] OP_LDYD_V = 16'h900A;
	// Two-word instructions that a skip must step over whole
	localparam logic [15:0] OP_LDS_M = 16'hFC0F;
	localparam logic [15:0] OP_LDS_V = 16'h9000;
	localparam logic [15:0] OP_JMP_M = 16'hFE0C;
	localparam logic [15:0] OP_JMP_V = 16'h940C;

	// Pointer access modes in the low opcode bits
	localparam logic [1:0] PTR_PLAIN = 2'h0;
	localparam logic [1:0] PTR_POST = 2'h1;
	localparam logic [1:0] PTR_PRE = 2'h2;

	// APB register offsets and reset values
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FLAGS = 8'h04;
	localparam logic [7:0] REG_PC = 8'h08;
	localparam logic [7:0] REG_PTR = 8'h0C;
	localparam int CTRL_RUN_BIT = 0;
	localparam logic CTRL_RUN_RST = 1'b1;

	// Execution sequencer states
	typedef enum logic [2:0] {
		ST_EXEC,
		ST_LOAD,
		ST_SKIP,
		ST_SKIP2,
		ST_STALL
	} cbl_state_e;

endpackage

// ### test/cbl_mem_model.sv
// Program and data memory model facing the execution block
`timescale 1ns/1ps
module cbl_mem_model (
	input wire logic i_ref_clk, // Core clock
	input wire logic [15:0] i_pc, // Program word address
	output logic [15:0] o_instr, // Instruction word
	input wire logic [15:0] i_addr, // Data byte address
	input wire logic i_rd, // Data read strobe
	output logic [7:0] o_data // Data read byte
);
	logic [15:0] prog [0:255];
	logic [7:0] data [0:511];
	logic [7:0] last_q = 8'h00;
	// Asynchronous program read, words past the table act as no-ops
	assign o_instr = (i_pc < 16'h0100) ? prog[i_pc[7:0]] : 16'h0000;
	// Byte only while strobed, otherwise a pattern that flips every cycle
	assign o_data = i_rd ? data[i_addr[8:0]] : ~last_q;
	// Remember what was shown so idle data never repeats it
	always_ff @(posedge i_ref_clk) begin
		last_q <= o_data;
	end
endmodule // cbl_mem_model

// ### test/tb_top.sv
// Self-checking bench for the compare, branch and load execution block
`timescale 1ns/1ps
module tb_top;
	import cbl_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b0;
	logic [15:0] pc, instr, daddr;
	logic drd;
	logic [7:0] ddata;
	logic [255:0] io_bits = '0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic pready, pslverr;
	int miscompares = 0;
	int checks = 0;
	logic [15:0] pw [$];

	// Clock at 10 MHz
	always #50 ref_clk = ~ref_clk;

	cbl_core uut (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_ce(ce), .o_pc(pc), .i_instr(instr),
		.o_dmem_addr(daddr), .o_dmem_rd(drd), .i_dmem_data(ddata), .i_io_bits(io_bits),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
	cbl_mem_model mem (.i_ref_clk(ref_clk), .i_pc(pc), .o_instr(instr), .i_addr(daddr),
		.i_rd(drd), .o_data(ddata));

	// Instruction word builders
	function automatic logic [15:0] rr(logic [15:0] op, int d, int r);
		return op | 16'((r & 16) << 5) | 16'(d << 4) | 16'(r & 15);
	endfunction
	function automatic logic [15:0] imm(logic [15:0] op, int d, int k);
		return op | 16'((k & 240) << 4) | 16'((d - 16) << 4) | 16'(k & 15);
	endfunction
	function automatic logic [15:0] ldp(logic [15:0] op, int d, int m);
		return op | 16'(d << 4) | 16'(m);
	endfunction
	function automatic logic [15:0] bsel(logic [15:0] op, int a, int b);
		return op | 16'(a << 3) | 16'(b);
	endfunction

	// Ends the run with the verdict
	task automatic test_done();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One APB transfer, held until pready is sampled high
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) chk("pready", 32'h0000_0001, 32'(pready));
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Counts executing edges until the program counter shows a target
	task automatic wait_pc(logic [15:0] t, output int n);
		n = 0;
		#1;
		while (pc !== t && n < 200) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		if (n >= 200) chk("pc reached", 32'(t), 32'(pc));
	endtask

	// Loads the program, restarts, measures cycles, then reads flags and pointers
	task automatic go(int e, int cyc, bit pre, logic [7:0] sr, logic [31:0] ptr);
		int n;
		logic [31:0] rd;
		logic err;
		@(posedge ref_clk);
		rst_n <= 1'b0;
		ce <= 1'b0;
		for (int i = 0; i < 256; i++) mem.prog[i] = (i < pw.size()) ? pw[i] : 16'h0000;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		chk("pc frozen", 32'h0000_0000, 32'(pc));
		@(posedge ref_clk);
		ce <= 1'b1;
		if (pre) begin
			apb(1'b1, REG_CTRL, 32'h0000_0000, rd, err);
			apb(1'b1, REG_FLAGS, 32'(sr), rd, err);
			apb(1'b1, REG_CTRL, 32'h0000_0001, rd, err);
		end
		wait_pc(16'(pre ? e - 4 : 0), n);
		wait_pc(16'(e), n);
		chk("cycles", 32'(cyc), 32'(n));
		apb(1'b1, REG_CTRL, 32'h0000_0000, rd, err);
		apb(1'b0, REG_FLAGS, 32'h0000_0000, rd, err);
		chk("flags", 32'(sr), rd);
		apb(1'b0, REG_PTR, 32'h0000_0000, rd, err);
		chk("ptr", ptr, rd);
		pw.delete();
	endtask

	// Watchdog cuts a hang short
	initial begin
		#3_000_000;
		miscompares++;
		test_done();
	end

	// Test sequence
	initial begin
		logic [31:0] rd;
		logic err;
		logic [7:0] sr;
		io_bits[42] = 1'b1;
		mem.data[9'h120] = 8'hA5;
		mem.data[9'h121] = 8'h5A;
		mem.data[9'h11F] = 8'h99;
		mem.data[9'h040] = 8'h3C;
		mem.data[9'h041] = 8'hC3;
		mem.data[9'h03F] = 8'h77;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		// Pointer loads in every mode, then copies
		pw = '{imm(16'hE000, 26, 8'h20), imm(16'hE000, 27, 8'h01), imm(16'hE000, 28, 8'h40),
			imm(16'hE000, 29, 8'h00), ldp(16'h900C, 5, 1), ldp(16'h900C, 6, 2),
			ldp(16'h900C, 10, 0), ldp(16'h9008, 7, 1), ldp(16'h9008, 8, 2),
			ldp(16'h8008, 9, 0), rr(16'h1400, 6, 10), rr(16'h0400, 8, 9),
			rr(16'h2C00, 27, 6), rr(16'h2C00, 26, 8), 16'h01ED, 16'h0000};
		go(16, 22, 1'b0, 8'h02, 32'hA53C_A53C);
		apb(1'b1, REG_PTR, 32'hFFFF_FFFF, rd, err);
		apb(1'b0, REG_PTR, 32'h0000_0000, rd, err);
		chk("ptr read only", 32'hA53C_A53C, rd);
		apb(1'b1, REG_FLAGS, 32'h0000_005A, rd, err);
		apb(1'b0, REG_FLAGS, 32'h0000_0000, rd, err);
		chk("flags write", 32'h0000_005A, rd);
		apb(1'b0, REG_CTRL, 32'h0000_0000, rd, err);
		chk("ctrl", 32'h0000_0000, rd);
		apb(1'b0, 8'h10, 32'h0000_0000, rd, err);
		chk("unmapped error", 32'h0000_0001, 32'(err));
		// Compare with borrow chain, then immediate compare with overflow
		pw = '{imm(16'hE000, 16, 8'h10), imm(16'hE000, 17, 8'h20), rr(16'h1400, 16, 17),
			rr(16'h0400, 16, 16), 16'h0000};
		go(5, 5, 1'b0, 8'h35, 32'h0000_0000);
		pw = '{imm(16'hE000, 17, 8'h80), imm(16'h3000, 17, 8'h01), bsel(16'hF000, 1, 4),
			imm(16'hE000, 26, 8'h01), bsel(16'hF400, 1, 4), imm(16'hE000, 27, 8'h5A),
			16'h0000};
		go(7, 7, 1'b0, 8'h38, 32'h0000_5A00);
		// Skips over one and two words, taken and not
		pw = '{imm(16'hE000, 16, 8'h55), imm(16'hE000, 17, 8'h55), rr(16'h1400, 16, 17),
			rr(16'h1000, 16, 17), imm(16'hE000, 26, 8'hEE), bsel(16'hFC00, 32, 1),
			16'h940C, 16'h0000, bsel(16'hFE00, 32, 1), imm(16'hE000, 27, 8'h11),
			bsel(16'h9900, 5, 3), imm(16'hE000, 27, 8'h22), bsel(16'h9B00, 5, 2),
			imm(16'hE000, 27, 8'h33), rr(16'h1000, 16, 26), imm(16'hE000, 26, 8'h77),
			16'h0000};
		go(17, 17, 1'b0, 8'h02, 32'h0000_1177);
		// Every flag index, both forms, taken and not taken
		for (int s = 0; s < 8; s++) begin
			for (int f = 0; f < 2; f++) begin
				for (int t = 0; t < 2; t++) begin
					sr = (f == t) ? 8'(1 << s) : ~8'(1 << s);
					pw = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
						16'h0000, 16'h0000, bsel(f ? 16'hF000 : 16'hF400, 2, s),
						imm(16'hE000, 26, 8'h01), imm(16'hE000, 27, 8'h02), 16'h0000};
					go(12, t ? 3 : 4, 1'b1, sr, t ? 32'h0000_0000 : 32'h0000_0201);
				end
			end
		end
		test_done();
	end
endmodule // tb_top
